// [hdl/fatv_cp15_regs.v]
/*
  Fault address, translation result and vector base registers of the
  system control coprocessor, with Secure and Non-secure copies.
  Assumes all inputs come from core logic on ref_clk_i, so none is
  synchronised; the pipeline presents one coprocessor move per valid.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fatv_defs.vh"


module fatv_cp15_regs (
  input  wire        ref_clk_i,     // Core clock, 250 MHz
  input  wire        rst_n_i,       // Synchronous reset, active low
  input  wire        secure_i,      // Core is in Secure state
  input  wire        priv_i,        // Core is in a privileged mode
  input  wire        mon_ns_i,      // Secure monitor targets Non-secure copies
  input  wire        cp_valid_i,    // Coprocessor move request
  input  wire        cp_write_i,    // 1 write to register, 0 read
  input  wire [2:0]  cp_op1_i,      // First opcode
  input  wire [3:0]  cp_crn_i,      // Primary register
  input  wire [3:0]  cp_crm_i,      // Secondary register
  input  wire [2:0]  cp_op2_i,      // Second opcode
  input  wire [31:0] cp_wdata_i,    // Write data
  input  wire        dfault_i,      // Synchronous data fault, one cycle
  input  wire [31:0] dfault_mva_i,  // Faulting data address
  input  wire        pabort_i,      // Prefetch abort, one cycle
  input  wire [31:0] pabort_mva_i,  // Faulting instruction address
  input  wire        xlat_done_i,   // Translation operation finished
  input  wire        xlat_fail_i,   // Translation aborted
  input  wire [19:0] xlat_pa_i,     // Physical address bits 31..12
  input  wire        xlat_ns_i,     // Entry non-secure bit
  input  wire        xlat_sh_i,     // Memory shareable
  input  wire [2:0]  xlat_inner_i,  // Inner attribute code
  input  wire [1:0]  xlat_outer_i,  // Outer attribute code
  input  wire        xlat_super_i,  // Supersection translation
  input  wire [4:0]  xlat_fs_i,     // Fault status code of the abort
  input  wire        xlat_ext_i,    // External abort qualifier
  output reg  [31:0] cp_rdata_o,    // Read data, valid with ack
  output reg         cp_ack_o,      // Request done, one cycle
  output reg         cp_undef_o,    // Request refused, one cycle
  output reg  [31:0] vec_base_o     // Vector base for current state
);

  // -----------------------------------------------------------------------
  // Decode of coprocessor register codes
  // -----------------------------------------------------------------------

  // Maps an access code to the register it selects
  function [2:0] fatv_decode;
    input [2:0] op1;
    input [3:0] crn;
    input [3:0] crm;
    input [2:0] op2;
    begin
      fatv_decode = `FATV_SEL_NONE;
      if (op1 == `FATV_OP1_ALL)
      begin
        if (crn == `FATV_CRN_FAULT && crm == `FATV_CRM_ZERO &&
            op2 == `FATV_OP2_DFA)
          fatv_decode = `FATV_SEL_DFA;
        else if (crn == `FATV_CRN_FAULT && crm == `FATV_CRM_ZERO &&
                 op2 == `FATV_OP2_IFA)
          fatv_decode = `FATV_SEL_IFA;
        else if (crn == `FATV_CRN_XLAT && crm == `FATV_CRM_XRES &&
                 op2 == `FATV_OP2_XRES)
          fatv_decode = `FATV_SEL_XLAT;
        else if (crn == `FATV_CRN_VEC && crm == `FATV_CRM_ZERO &&
                 op2 == `FATV_OP2_VEC)
          fatv_decode = `FATV_SEL_VEC;
        else if (crn == `FATV_CRN_XLAT && crm == `FATV_CRM_BARRIER &&
                 op2 == `FATV_OP2_BARRIER)
          fatv_decode = `FATV_SEL_BARRIER;
      end
    end
  endfunction

  // Picks the Secure or Non-secure copy
  function [31:0] fatv_pick;
    input        use_ns;
    input [31:0] s_val;
    input [31:0] ns_val;
    begin
      fatv_pick = use_ns ? ns_val : s_val;
    end
  endfunction

  // -----------------------------------------------------------------------
  // Request qualification
  // -----------------------------------------------------------------------
  wire [2:0] sel;       // Decoded target
  wire       bank_ns;   // Software reaches the Non-secure copies
  wire       state_ns;  // Core itself is in Non-secure state
  reg        legal;     // Request may proceed
  wire       sw_wr;     // Accepted software write

  assign sel      = fatv_decode(cp_op1_i, cp_crn_i, cp_crm_i, cp_op2_i);
  assign state_ns = ~secure_i;
  assign bank_ns  = state_ns | mon_ns_i;

  // Works out whether the request is allowed
  always @*
  begin
    legal = 1'b0;
    case (sel)
      `FATV_SEL_DFA,
      `FATV_SEL_IFA:
        legal = priv_i;
      `FATV_SEL_XLAT:
        legal = priv_i & ~cp_write_i;            // Read only
      `FATV_SEL_VEC:
        legal = priv_i & secure_i;
      `FATV_SEL_BARRIER:
        legal = cp_write_i;                      // Barrier takes no read
      default:
        legal = 1'b0;                            // Unmapped code
    endcase
  end

  assign sw_wr = cp_valid_i & legal & cp_write_i;

  // -----------------------------------------------------------------------
  // Data fault address
  // -----------------------------------------------------------------------
  wire        dfa_sw;    // Software writes this register
  wire        dfa_wr_s;  // Secure copy write
  wire        dfa_wr_ns; // Non-secure copy write
  wire [31:0] dfa_d;     // Data to store
  wire [31:0] dfa_s_q;   // Secure copy
  wire [31:0] dfa_ns_q;  // Non-secure copy

  // A fault in the same cycle as a software write wins
  assign dfa_sw    = sw_wr & (sel == `FATV_SEL_DFA);
  assign dfa_wr_s  = (dfault_i & secure_i) | (dfa_sw & ~bank_ns & ~dfault_i);
  assign dfa_wr_ns = (dfault_i & state_ns) | (dfa_sw & bank_ns & ~dfault_i);
  assign dfa_d     = dfault_i ? dfault_mva_i : cp_wdata_i;

  fatv_bank_reg #(
    .WIDTH (32),
    .RST   (`FATV_FAR_RST)
  ) u_dfa (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_s_i    (dfa_wr_s),
    .wr_ns_i   (dfa_wr_ns),
    .wdata_i   (dfa_d),
    .s_q_o     (dfa_s_q),
    .ns_q_o    (dfa_ns_q)
  );

  // -----------------------------------------------------------------------
  // Instruction fault address
  // -----------------------------------------------------------------------
  wire        ifa_sw;    // Software writes this register
  wire        ifa_wr_s;  // Secure copy write
  wire        ifa_wr_ns; // Non-secure copy write
  wire [31:0] ifa_d;     // Data to store
  wire [31:0] ifa_s_q;   // Secure copy
  wire [31:0] ifa_ns_q;  // Non-secure copy

  // Same priority as the data side: the abort wins over software
  assign ifa_sw    = sw_wr & (sel == `FATV_SEL_IFA);
  assign ifa_wr_s  = (pabort_i & secure_i) | (ifa_sw & ~bank_ns & ~pabort_i);
  assign ifa_wr_ns = (pabort_i & state_ns) | (ifa_sw & bank_ns & ~pabort_i);
  assign ifa_d     = pabort_i ? pabort_mva_i : cp_wdata_i;

  fatv_bank_reg #(
    .WIDTH (32),
    .RST   (`FATV_FAR_RST)
  ) u_ifa (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_s_i    (ifa_wr_s),
    .wr_ns_i   (ifa_wr_ns),
    .wdata_i   (ifa_d),
    .s_q_o     (ifa_s_q),
    .ns_q_o    (ifa_ns_q)
  );

  // -----------------------------------------------------------------------
  // Translation result
  // -----------------------------------------------------------------------
  wire [31:0] par_d;     // Packed outcome
  wire [31:0] par_s_q;   // Secure copy
  wire [31:0] par_ns_q;  // Non-secure copy

  fatv_xlat_fmt u_fmt (
    .fail_i  (xlat_fail_i),
    .pa_i    (xlat_pa_i),
    .ns_i    (xlat_ns_i),
    .sh_i    (xlat_sh_i),
    .inner_i (xlat_inner_i),
    .outer_i (xlat_outer_i),
    .super_i (xlat_super_i),
    .fs_i    (xlat_fs_i),
    .ext_i   (xlat_ext_i),
    .par_o   (par_d)
  );

  // Only hardware loads it; the copy follows bank_ns, the core state or the monitor selection
  fatv_bank_reg #(
    .WIDTH (32),
    .RST   (`FATV_XR_RST)
  ) u_par (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_s_i    (xlat_done_i & ~bank_ns),
    .wr_ns_i   (xlat_done_i & bank_ns),
    .wdata_i   (par_d),
    .s_q_o     (par_s_q),
    .ns_q_o    (par_ns_q)
  );

  // -----------------------------------------------------------------------
  // Exception vector base
  // -----------------------------------------------------------------------
  wire        vec_sw;    // Software writes the vector base
  wire [26:0] vec_s_q;   // Secure copy, bits 31..5
  wire [26:0] vec_ns_q;  // Non-secure copy, bits 31..5

  assign vec_sw = sw_wr & (sel == `FATV_SEL_VEC);

  // Low five bits are dropped on write
  fatv_bank_reg #(
    .WIDTH (27),
    .RST   (`FATV_VEC_RST)
  ) u_vec (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_s_i    (vec_sw & ~bank_ns),
    .wr_ns_i   (vec_sw & bank_ns),
    .wdata_i   (cp_wdata_i[31:`FATV_VEC_LSB]),
    .s_q_o     (vec_s_q),
    .ns_q_o    (vec_ns_q)
  );

  // -----------------------------------------------------------------------
  // Read data selection
  // -----------------------------------------------------------------------
  reg [31:0] rdata_nxt;  // Data for the answer

  // Chooses the copy seen by the requester
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (sel)
      `FATV_SEL_DFA:
        rdata_nxt = fatv_pick(bank_ns, dfa_s_q, dfa_ns_q);
      `FATV_SEL_IFA:
        rdata_nxt = fatv_pick(bank_ns, ifa_s_q, ifa_ns_q);
      `FATV_SEL_XLAT:
        rdata_nxt = fatv_pick(bank_ns, par_s_q, par_ns_q);
      `FATV_SEL_VEC:
        rdata_nxt = fatv_pick(bank_ns, {vec_s_q, 5'h00},
                              {vec_ns_q, 5'h00});
      default:
        rdata_nxt = 32'h0000_0000;                          // Barrier, none
    endcase
  end

  // -----------------------------------------------------------------------
  // Answer to the pipeline
  // -----------------------------------------------------------------------

  // One answer per request, one cycle after it is taken
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cp_ack_o   <= 1'b0;
      cp_undef_o <= 1'b0;
      cp_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      cp_ack_o   <= cp_valid_i & legal;
      cp_undef_o <= cp_valid_i & ~legal;
      if (cp_valid_i & legal & ~cp_write_i)
        cp_rdata_o <= rdata_nxt;
      else
        cp_rdata_o <= 32'h0000_0000;      // Barrier ack carries nothing
    end
  end

  // -----------------------------------------------------------------------
  // Vector base for the exception logic
  // -----------------------------------------------------------------------

  // Follows the core's own security state, not the monitor selection
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      vec_base_o <= 32'h0000_0000;
    else if (state_ns)
      vec_base_o <= {vec_ns_q, 5'h00};
    else
      vec_base_o <= {vec_s_q, 5'h00};
  end

endmodule // fatv_cp15_regs

`default_nettype wire

// [hdl/fatv_defs.vh]
/*
  Constants for the fault address, translation result and vector base
  register group: coprocessor access codes, field positions, reset values.
  Assumes it is included by bare name from the design files that need it.
*/
`ifndef FATV_DEFS_VH
`define FATV_DEFS_VH

// -----------------------------------------------------------------------
// Coprocessor access codes
// -----------------------------------------------------------------------
`define FATV_OP1_ALL      3'h0
`define FATV_CRN_FAULT    4'h6
`define FATV_CRN_XLAT     4'h7
`define FATV_CRN_VEC      4'hC
`define FATV_CRM_ZERO     4'h0
`define FATV_CRM_XRES     4'h4
`define FATV_CRM_BARRIER  4'hA
`define FATV_OP2_DFA      3'h0
`define FATV_OP2_IFA      3'h2
`define FATV_OP2_XRES     3'h0
`define FATV_OP2_VEC      3'h0
`define FATV_OP2_BARRIER  3'h4

// -----------------------------------------------------------------------
// Decoded target codes
// -----------------------------------------------------------------------
`define FATV_SEL_NONE     3'h0
`define FATV_SEL_DFA      3'h1
`define FATV_SEL_IFA      3'h2
`define FATV_SEL_XLAT     3'h3
`define FATV_SEL_VEC      3'h4
`define FATV_SEL_BARRIER  3'h5

// -----------------------------------------------------------------------
// Translation result and vector base field positions
// -----------------------------------------------------------------------
`define FATV_XR_FAIL      0
`define FATV_XR_SUPER     1
`define FATV_XR_OUTER     2
`define FATV_XR_INNER     4
`define FATV_XR_SHARE     7
`define FATV_XR_NSEC      9
`define FATV_XR_PA        12
`define FATV_XR_FS        1
`define FATV_XR_EXT       12
`define FATV_VEC_LSB      5

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define FATV_FAR_RST      32'h0000_0000
`define FATV_XR_RST       32'h0000_0000
`define FATV_VEC_RST      27'h000_0000

`endif

// [hdl/fatv_bank_reg.v]
/*
  One register held as a Secure and a Non-secure copy.
  Assumes the caller raises at most one write enable per copy per cycle
  and has already resolved priority between hardware and software writes.
*/
`timescale 1ns/100ps
`default_nettype none

module fatv_bank_reg #(
  parameter         WIDTH = 32,              // Register width
  parameter [WIDTH-1:0] RST = {WIDTH{1'b0}}  // Reset value of both copies
) (
  input  wire             ref_clk_i,  // Core clock
  input  wire             rst_n_i,    // Synchronous reset, active low
  input  wire             wr_s_i,     // Write the Secure copy
  input  wire             wr_ns_i,    // Write the Non-secure copy
  input  wire [WIDTH-1:0] wdata_i,    // Data for either copy
  output wire [WIDTH-1:0] s_q_o,      // Secure copy
  output wire [WIDTH-1:0] ns_q_o      // Non-secure copy
);

  reg [WIDTH-1:0] s_r;   // Secure copy
  reg [WIDTH-1:0] ns_r;  // Non-secure copy

  // -----------------------------------------------------------------------
  // Storage of both copies
  // -----------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_r  <= RST;
      ns_r <= RST;
    end
    else
    begin
      if (wr_s_i)
        s_r <= wdata_i;
      if (wr_ns_i)
        ns_r <= wdata_i;
    end
  end

  assign s_q_o  = s_r;
  assign ns_q_o = ns_r;

endmodule // fatv_bank_reg

`default_nettype wire

// [hdl/fatv_xlat_fmt.v]
/*
  Packs one address translation outcome into the translation result layout.
  Assumes attribute inputs already carry the encodings of the result fields.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fatv_defs.vh"

module fatv_xlat_fmt (
  input  wire        fail_i,   // Translation aborted
  input  wire [19:0] pa_i,     // Physical address bits 31..12
  input  wire        ns_i,     // Non-secure bit of the table entry
  input  wire        sh_i,     // Memory is shareable
  input  wire [2:0]  inner_i,  // Inner attribute code
  input  wire [1:0]  outer_i,  // Outer attribute code
  input  wire        super_i,  // Supersection used
  input  wire [4:0]  fs_i,     // Fault status code
  input  wire        ext_i,    // External abort: 0 decode, 1 slave error
  output reg  [31:0] par_o     // Packed result
);

  // -----------------------------------------------------------------------
  // Success and abort layouts, reserved bits held at zero
  // -----------------------------------------------------------------------
  always @*
  begin
    par_o = 32'h0000_0000;
    if (fail_i)
    begin
      par_o[`FATV_XR_FAIL]               = 1'b1;
      par_o[`FATV_XR_FS+4:`FATV_XR_FS]   = fs_i;
      par_o[`FATV_XR_EXT]                = ext_i;
    end
    else
    begin
      par_o[`FATV_XR_FAIL]                   = 1'b0;
      par_o[31:`FATV_XR_PA]                  = pa_i;
      par_o[`FATV_XR_NSEC]                   = ns_i;
      par_o[`FATV_XR_SHARE]                  = sh_i;
      par_o[`FATV_XR_INNER+2:`FATV_XR_INNER] = inner_i;
      par_o[`FATV_XR_OUTER+1:`FATV_XR_OUTER] = outer_i;
      par_o[`FATV_XR_SUPER]                  = super_i;
    end
  end

endmodule // fatv_xlat_fmt

`default_nettype wire

// [dv/fatv_regs_checker.sv]
/*
  Checker for the fault address, translation result and vector base group.
  Assumes it is bound to fatv_cp15_regs: one clock, synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// Port timing and refusal checker
// ---------------------------------------------------------------------
module fatv_regs_checker (
  input wire logic        ref_clk_i,   // Core clock
  input wire logic        rst_n_i,     // Reset, active low
  input wire logic        secure_i,    // Secure state
  input wire logic        priv_i,      // Privileged mode
  input wire logic        cp_valid_i,  // Request strobe
  input wire logic        cp_write_i,  // Write request
  input wire logic [2:0]  cp_op1_i,    // First opcode
  input wire logic [3:0]  cp_crn_i,    // Primary register
  input wire logic [3:0]  cp_crm_i,    // Secondary register
  input wire logic [2:0]  cp_op2_i,    // Second opcode
  input wire logic [31:0] cp_rdata_o,  // Read data
  input wire logic        cp_ack_o,    // Done pulse
  input wire logic        cp_undef_o,  // Refused pulse
  input wire logic [31:0] vec_base_o   // Vector base
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Decoded requests of interest
  wire fault_hit = cp_valid_i && cp_crn_i == 4'h6;
  wire c7_wr     = cp_valid_i && cp_write_i && cp_op1_i == 3'h0 && cp_crn_i == 4'h7;
  wire xlat_wr   = c7_wr && cp_crm_i == 4'h4 && cp_op2_i == 3'h0;
  wire dsb_wr    = c7_wr && cp_crm_i == 4'hA && cp_op2_i == 3'h4;

  answer_one_a: assert property (cp_valid_i |=> cp_ack_o != cp_undef_o)
    else $error("request not answered by exactly one pulse");
  idle_quiet_a: assert property (!cp_valid_i |=> !cp_ack_o && !cp_undef_o)
    else $error("answer pulse without request");
  unpriv_refuse_a: assert property (fault_hit && !priv_i |=> cp_undef_o && cp_rdata_o == 32'h0)
    else $error("unprivileged fault register access not refused");
  op1_refuse_a: assert property (cp_valid_i && cp_op1_i != 3'h0 |=> cp_undef_o)
    else $error("nonzero first opcode not refused");
  xlat_ro_a: assert property (xlat_wr |=> cp_undef_o)
    else $error("translation result write not refused");
  vec_secure_a: assert property (cp_valid_i && cp_crn_i == 4'hC && !secure_i |=> cp_undef_o)
    else $error("vector base access outside Secure state not refused");
  vec_low_a: assert property (vec_base_o[4:0] == 5'h00)
    else $error("vector base low bits not zero");
  barrier_nop_a: assert property (dsb_wr |=> cp_ack_o && cp_rdata_o == 32'h0)
    else $error("barrier write not acknowledged");
  rdata_ack_a: assert property (cp_rdata_o != 32'h0 |-> cp_ack_o)
    else $error("read data outside acknowledge");
endmodule // fatv_regs_checker

bind fatv_cp15_regs fatv_regs_checker fatv_regs_checker_inst (.ref_clk_i, .rst_n_i,
  .secure_i, .priv_i, .cp_valid_i, .cp_write_i, .cp_op1_i, .cp_crn_i, .cp_crm_i,
  .cp_op2_i, .cp_rdata_o, .cp_ack_o, .cp_undef_o, .vec_base_o);

`default_nettype wire

// [dv/tb.sv]
/*
  Self-checking testbench for the coprocessor register group.
  Assumes fatv_cp15_regs answers one cycle after each request.
*/
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// Testbench top
// ---------------------------------------------------------------------
module tb;
  logic        ref_clk_i, rst_n_i, secure_i, priv_i, mon_ns_i;  // Clock and state
  logic        cp_valid_i, cp_write_i;                          // Request strobe
  logic [2:0]  cp_op1_i, cp_op2_i;                              // Opcodes
  logic [3:0]  cp_crn_i, cp_crm_i;                              // Register codes
  logic [31:0] cp_wdata_i, dfault_mva_i, pabort_mva_i;          // Data and addresses
  logic        dfault_i, pabort_i, xlat_done_i, xlat_fail_i;    // Events
  logic [19:0] xlat_pa_i;                                       // Physical address
  logic        xlat_ns_i, xlat_sh_i, xlat_super_i, xlat_ext_i;  // Attribute bits
  logic [2:0]  xlat_inner_i;                                    // Inner code
  logic [1:0]  xlat_outer_i;                                    // Outer code
  logic [4:0]  xlat_fs_i;                                       // Fault status
  wire  [31:0] cp_rdata_o, vec_base_o;                          // Outputs
  wire         cp_ack_o, cp_undef_o;                            // Answer pulses
  int          n_mismatch, checks;                              // Counters

  fatv_cp15_regs fatv_cp15_regs_inst (.ref_clk_i, .rst_n_i, .secure_i, .priv_i,
    .mon_ns_i, .cp_valid_i, .cp_write_i, .cp_op1_i, .cp_crn_i, .cp_crm_i, .cp_op2_i,
    .cp_wdata_i, .dfault_i, .dfault_mva_i, .pabort_i, .pabort_mva_i, .xlat_done_i,
    .xlat_fail_i, .xlat_pa_i, .xlat_ns_i, .xlat_sh_i, .xlat_inner_i, .xlat_outer_i,
    .xlat_super_i, .xlat_fs_i, .xlat_ext_i, .cp_rdata_o, .cp_ack_o, .cp_undef_o,
    .vec_base_o);

  // Clock at 4 ns period
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Comparison and report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One request, answer judged one cycle later
  task acc(input logic w, input logic [2:0] o1, input logic [3:0] n, input logic [3:0] m,
           input logic [2:0] o2, input logic [31:0] wd, input logic xu, input logic [31:0] xr);
    @(negedge ref_clk_i);
    {cp_valid_i, cp_write_i, cp_op1_i, cp_crn_i, cp_crm_i, cp_op2_i, cp_wdata_i} =
      {1'b1, w, o1, n, m, o2, wd};
    @(negedge ref_clk_i);
    cp_valid_i = 1'b0;
    chk({31'h0, cp_ack_o}, {31'h0, ~xu});
    chk({31'h0, cp_undef_o}, {31'h0, xu});
    chk(cp_rdata_o, xr);
  endtask

  task rd(input logic [3:0] n, input logic [3:0] m, input logic [2:0] o2, input logic [31:0] x);
    acc(1'b0, 3'h0, n, m, o2, 32'h0, 1'b0, x);
  endtask

  task wr(input logic [3:0] n, input logic [3:0] m, input logic [2:0] o2, input logic [31:0] d);
    acc(1'b1, 3'h0, n, m, o2, d, 1'b0, 32'h0);
  endtask

  // Fault event pulse: p=1 prefetch abort, p=0 data fault
  task flt(input logic p, input logic [31:0] a);
    @(negedge ref_clk_i);
    {dfault_i, dfault_mva_i, pabort_i, pabort_mva_i} = {~p, a, p, a};
    @(negedge ref_clk_i);
    {dfault_i, pabort_i} = 2'b00;
  endtask

  // Translation finish pulse with all fields
  task xl(input logic [34:0] v);
    @(negedge ref_clk_i);
    {xlat_fail_i, xlat_pa_i, xlat_ns_i, xlat_sh_i, xlat_inner_i, xlat_outer_i,
     xlat_super_i, xlat_fs_i, xlat_ext_i} = v;
    xlat_done_i = 1'b1;
    @(negedge ref_clk_i);
    xlat_done_i = 1'b0;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task t_reset;
    rd(4'h6, 4'h0, 3'h0, 32'h0);
    rd(4'h6, 4'h0, 3'h2, 32'h0);
    rd(4'h7, 4'h4, 3'h0, 32'h0);
    chk(vec_base_o, 32'h0);
    $display("test reset done");
  endtask

  task t_fault;
    wr(4'h6, 4'h0, 3'h0, 32'hCAFE_0001);
    rd(4'h6, 4'h0, 3'h0, 32'hCAFE_0001);
    flt(1'b0, 32'h8000_0040);
    rd(4'h6, 4'h0, 3'h0, 32'h8000_0040);
    wr(4'h6, 4'h0, 3'h2, 32'h0000_0FFC);
    rd(4'h6, 4'h0, 3'h2, 32'h0000_0FFC);
    flt(1'b1, 32'h7FFF_FFFE);
    rd(4'h6, 4'h0, 3'h2, 32'h7FFF_FFFE);
    rd(4'h6, 4'h0, 3'h0, 32'h8000_0040);
    secure_i = 1'b0;
    rd(4'h6, 4'h0, 3'h0, 32'h0);
    flt(1'b0, 32'h1111_2222);
    rd(4'h6, 4'h0, 3'h0, 32'h1111_2222);
    secure_i = 1'b1;
    rd(4'h6, 4'h0, 3'h0, 32'h8000_0040);
    $display("test fault done");
  endtask

  task t_priv;
    priv_i = 1'b0;
    acc(1'b0, 3'h0, 4'h6, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 3'h0, 4'h6, 4'h0, 3'h2, 32'h5555_5555, 1'b1, 32'h0);
    acc(1'b0, 3'h0, 4'h7, 4'h4, 3'h0, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 3'h0, 4'h7, 4'hA, 3'h4, 32'h0, 1'b0, 32'h0);
    priv_i = 1'b1;
    rd(4'h6, 4'h0, 3'h2, 32'h7FFF_FFFE);
    acc(1'b0, 3'h0, 4'h7, 4'hA, 3'h4, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 3'h1, 4'h6, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 3'h0, 4'h3, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    $display("test privilege done");
  endtask

  task t_xlat;
    logic [2:0] inn [6];
    logic [19:0] pa;
    logic [1:0] i2;
    inn = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 6; i++)
    begin
      pa = 20'hA5000 + 20'(i);
      i2 = 2'(i);
      xl({1'b0, pa, i2[0], i2[1], inn[i], i2, ~i2[0], 5'h1F, 1'b1});
      rd(4'h7, 4'h4, 3'h0, {pa, 2'h0, i2[0], 1'b0, i2[1], inn[i], i2, ~i2[0], 1'b0});
    end
    for (int e = 0; e < 2; e++)
    begin
      xl({1'b1, 20'hFFFFF, 2'h3, 3'h7, 2'h3, 1'b1, 5'h0D, 1'(e)});
      rd(4'h7, 4'h4, 3'h0, {19'h0, 1'(e), 6'h0, 5'h0D, 1'b1});
    end
    acc(1'b1, 3'h0, 4'h7, 4'h4, 3'h0, 32'hFFFF_FFFF, 1'b1, 32'h0);
    secure_i = 1'b0;
    xl({1'b0, 20'h12345, 1'b1, 1'b0, 3'h5, 2'h1, 1'b0, 5'h00, 1'b0});
    rd(4'h7, 4'h4, 3'h0, 32'h1234_5254);
    secure_i = 1'b1;
    rd(4'h7, 4'h4, 3'h0, 32'h0000_101B);
    $display("test translation done");
  endtask

  task t_vec;
    wr(4'hC, 4'h0, 3'h0, 32'hFFFF_FFFF);
    rd(4'hC, 4'h0, 3'h0, 32'hFFFF_FFE0);
    @(negedge ref_clk_i);
    chk(vec_base_o, 32'hFFFF_FFE0);
    mon_ns_i = 1'b1;
    wr(4'hC, 4'h0, 3'h0, 32'h1234_5678);
    mon_ns_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(vec_base_o, 32'hFFFF_FFE0);
    secure_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(vec_base_o, 32'h1234_5660);
    acc(1'b0, 3'h0, 4'hC, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    secure_i = 1'b1;
    $display("test vector done");
  endtask

  // Hang guard
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    checks = 0;
    {rst_n_i, secure_i, priv_i, mon_ns_i, cp_valid_i, cp_write_i} = 6'b011000;
    {cp_op1_i, cp_op2_i, cp_crn_i, cp_crm_i, cp_wdata_i} = 46'h0;
    {dfault_i, dfault_mva_i, pabort_i, pabort_mva_i, xlat_done_i} = 67'h0;
    {xlat_fail_i, xlat_pa_i, xlat_ns_i, xlat_sh_i, xlat_inner_i} = 26'h0;
    {xlat_outer_i, xlat_super_i, xlat_fs_i, xlat_ext_i} = 9'h0;
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_fault();
    t_priv();
    t_xlat();
    t_vec();
    conclude();
  end
endmodule // tb

`default_nettype wire
